// ==== rtl/fgscm_pkg.sv ====
// shared constants, state types and carriers of the standard-command map
package fgscm_pkg;
  // host-visible command codes, low byte of each pair
  localparam logic [7:0] CMD_CTRL         = 8'h00;
  localparam logic [7:0] CMD_AT_RATE      = 8'h02;
  localparam logic [7:0] CMD_AT_RATE_EMPT = 8'h04;
  localparam logic [7:0] CMD_THERMAL      = 8'h06;
  localparam logic [7:0] CMD_POTENTIAL    = 8'h08;
  localparam logic [7:0] CMD_STATUS_BITS  = 8'h0A;
  localparam logic [7:0] CMD_NOM_CAP      = 8'h0C;
  localparam logic [7:0] CMD_FULL_AVAIL   = 8'h0E;
  localparam logic [7:0] CMD_REMAIN       = 8'h10;
  localparam logic [7:0] CMD_FULL_CHG     = 8'h12;
  localparam logic [7:0] CMD_AVG_CUR      = 8'h14;
  localparam logic [7:0] CMD_EMPTY_TIME   = 8'h16;
  localparam logic [7:0] CMD_FULL_TIME    = 8'h18;
  localparam logic [7:0] CMD_STBY_CUR     = 8'h1A;
  localparam logic [7:0] CMD_STBY_EMPTY   = 8'h1C;
  localparam logic [7:0] CMD_MAXL_CUR     = 8'h1E;
  localparam logic [7:0] CMD_MAXL_EMPTY   = 8'h20;
  localparam logic [7:0] CMD_AVAIL_ENERGY = 8'h22;
  localparam logic [7:0] CMD_AVG_POWER    = 8'h24;
  localparam logic [7:0] CMD_CP_EMPTY     = 8'h26;
  localparam logic [7:0] CMD_RESERVED     = 8'h28;
  localparam logic [7:0] CMD_CYCLES       = 8'h2A;
  localparam logic [7:0] CMD_CHARGE_PCT   = 8'h2C;
  // user storage: block select and a 32-byte window
  localparam logic [7:0] CMD_MIB_SEL      = 8'h3E;
  localparam logic [7:0] CMD_MIB_FIRST    = 8'h40;
  localparam logic [7:0] CMD_MIB_LAST     = 8'h5F;
  localparam logic [7:0] MIB_BLOCKS       = 8'h03;
  localparam int         MIB_BYTES        = 96;
  // control subcommands acted on here
  localparam logic [15:0] SUB_SET_DEEP    = 16'h0010;
  localparam logic [15:0] SUB_SET_DORMANT = 16'h0011;
  localparam logic [15:0] SUB_CLR_DORMANT = 16'h0012;
  localparam logic [15:0] SUB_SET_PREOFF  = 16'h0013;
  localparam logic [15:0] SUB_CLR_PREOFF  = 16'h0014;
  localparam logic [15:0] SUB_LOCK        = 16'h0020;
  // bus address, arbitrary default
  localparam logic [6:0]  DEV_ADDR_DFLT   = 7'h2A;
  localparam logic [15:0] AT_RATE_RST     = 16'h0000;
  localparam logic [3:0]  BITS_PER_BYTE   = 4'h8;

  typedef enum logic [2:0] {
    PWR_NORMAL, PWR_LIGHT_SLEEP, PWR_DEEP_SLEEP, PWR_DORMANT, PWR_PRE_POWER_OFF
  } fgscm_pwr_t;
  typedef enum logic [2:0] {
    I2C_IDLE, I2C_ADDR, I2C_ACK_ADDR, I2C_WR_BYTE, I2C_ACK_WR, I2C_RD_BYTE, I2C_ACK_RD
  } fgscm_i2c_t;

  typedef struct packed { logic scl; logic sda; } fgscm_pin_in_t;
  typedef struct packed { logic sda_out; logic sda_oe_b; } fgscm_pin_out_t;
  typedef struct packed { logic valid; logic [15:0] word; } fgscm_ctrl_t;
  typedef struct packed {
    logic [15:0] at_rate_empt, potential_mv, status_bits, nom_cap, full_avail_cap;
    logic [15:0] remain_cap, full_chg_cap, avg_current, empty_time, full_time;
    logic [15:0] stby_current, stby_empty, maxl_current, maxl_empty, avail_energy;
    logic [15:0] avg_power, cp_empty, cycles, charge_pct;
  } fgscm_meas_t;
  typedef struct packed {
    logic bus_wake, deep_set, dormant_set, dormant_clr, preoff_en, preoff_dis;
  } fgscm_pwr_req_t;

  typedef struct packed { logic q1, q2, q3, lvl; } fgscm_sync_t;
  localparam fgscm_sync_t SYNC_RST = '{default: 1'b1};

  typedef struct packed {
    fgscm_pwr_t mode;
    logic deep, dormant, preoff_en;
  } fgscm_pwr_st_t;
  localparam fgscm_pwr_st_t PWR_RST = '{mode: PWR_NORMAL, default: 1'b0};

  typedef struct packed {
    fgscm_i2c_t st;
    logic scl_d, sda_d, rd, first, ackd, locked, sda_out, sda_oe_b, ctrl_valid;
    logic [3:0] bitcnt;
    logic [7:0] shreg, ptr, ctrl_lo;
    logic [15:0] at_rate, ctrl_word;
    logic [1:0] mib_sel;
    logic [MIB_BYTES-1:0][7:0] mib;
    fgscm_pwr_req_t preq;
  } fgscm_core_t;
  localparam fgscm_core_t CORE_RST = '{st: I2C_IDLE, scl_d: 1'b1, sda_d: 1'b1,
    sda_oe_b: 1'b1, at_rate: AT_RATE_RST, default: '0};
endpackage

// ==== rtl/fgscm_pin_sync.sv ====
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module fgscm_pin_sync (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // pin and filtered level
  input  wire logic pin,
  output logic      lvl
);
  fgscm_pkg::fgscm_sync_t r;
  fgscm_pkg::fgscm_sync_t next_r;

  always_comb begin
    next_r = r;
    next_r.q1 = pin;
    next_r.q2 = r.q1;
    next_r.q3 = r.q2;
    if (r.q2 == r.q3) begin
      next_r.lvl = r.q3;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      r <= fgscm_pkg::SYNC_RST;
    end else begin
      r <= next_r;
    end
  end

  assign lvl = r.lvl;
endmodule

// ==== rtl/fgscm_pwr.sv ====
// automatic power-mode sequencer
`timescale 1ns/1ps
module fgscm_pwr (
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst_b,
  // requests and conditions
  input  wire fgscm_pkg::fgscm_pwr_req_t req,
  input  wire logic                      sleep_ok,
  input  wire logic                      power_fail,
  // current mode
  output fgscm_pkg::fgscm_pwr_t          mode
);
  fgscm_pkg::fgscm_pwr_st_t r;
  fgscm_pkg::fgscm_pwr_st_t next_r;

  always_comb begin
    next_r = r;
    if (req.deep_set) next_r.deep = 1'b1;
    if (req.dormant_set) next_r.dormant = 1'b1;
    else if (req.dormant_clr) next_r.dormant = 1'b0;
    if (req.preoff_en) next_r.preoff_en = 1'b1;
    else if (req.preoff_dis) next_r.preoff_en = 1'b0;
    if (r.preoff_en && power_fail && r.mode != fgscm_pkg::PWR_PRE_POWER_OFF) begin
      next_r.mode = fgscm_pkg::PWR_PRE_POWER_OFF;
    end else begin
      case (r.mode)
        fgscm_pkg::PWR_NORMAL: begin
          if (sleep_ok && !req.bus_wake) next_r.mode = fgscm_pkg::PWR_LIGHT_SLEEP;
        end
        fgscm_pkg::PWR_LIGHT_SLEEP: begin
          if (!sleep_ok || req.bus_wake) next_r.mode = fgscm_pkg::PWR_NORMAL;
          else if (r.dormant) next_r.mode = fgscm_pkg::PWR_DORMANT;
          else if (r.deep) next_r.mode = fgscm_pkg::PWR_DEEP_SLEEP;
        end
        fgscm_pkg::PWR_DEEP_SLEEP: begin
          // any traffic drops back to light sleep and forgets the request
          if (req.bus_wake || !sleep_ok) begin
            next_r.deep = 1'b0;
            next_r.mode = req.bus_wake ? fgscm_pkg::PWR_LIGHT_SLEEP : fgscm_pkg::PWR_NORMAL;
          end
        end
        fgscm_pkg::PWR_DORMANT: begin
          if (req.bus_wake || !sleep_ok || req.dormant_clr) begin
            next_r.dormant = 1'b0;
            next_r.mode = fgscm_pkg::PWR_NORMAL;
          end
        end
        fgscm_pkg::PWR_PRE_POWER_OFF: begin
          if (!power_fail) next_r.mode = fgscm_pkg::PWR_NORMAL;
        end
        default: next_r.mode = fgscm_pkg::PWR_NORMAL;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) r <= fgscm_pkg::PWR_RST;
    else r <= next_r;
  end

  assign mode = r.mode;

  a_deep_wake: assert property (@(posedge clk) disable iff (!rst_b)
    (r.mode == fgscm_pkg::PWR_DEEP_SLEEP && req.bus_wake)
      |=> (r.mode == fgscm_pkg::PWR_LIGHT_SLEEP && !r.deep))
    else $error("deep sleep did not fall back to light sleep on traffic");
endmodule

// ==== rtl/fgscm_top.sv ====
// standard-command map of the fuel gauge behind its serial two-wire port
`timescale 1ns/1ps
module fgscm_top #(
  parameter logic [6:0] DEV_ADDR = fgscm_pkg::DEV_ADDR_DFLT
) (
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst_b,
  // serial port pins
  input  wire fgscm_pkg::fgscm_pin_in_t  pin_in,
  output fgscm_pkg::fgscm_pin_out_t      pin_out,
  // gauge core quantities
  input  wire fgscm_pkg::fgscm_meas_t    meas,
  input  wire logic [15:0]               therm_ext,
  input  wire logic [15:0]               therm_int,
  input  wire logic                      temp_src_internal,
  input  wire logic [15:0]               ctrl_rsp,
  // power conditions
  input  wire logic                      sleep_ok,
  input  wire logic                      power_fail,
  // control and status out
  output fgscm_pkg::fgscm_ctrl_t         ctrl_cmd,
  output logic [15:0]                    at_rate_setpoint,
  output logic                           locked,
  output fgscm_pkg::fgscm_pwr_t          pwr_mode
);
  fgscm_pkg::fgscm_core_t r;
  fgscm_pkg::fgscm_core_t next_r;
  logic                   scl;
  logic                   sda;
  logic                   rise;
  logic                   fall;
  logic                   start;
  logic                   stop;
  logic                   byte_done;
  logic                   wr_fire;
  logic [6:0]             mib_idx;
  logic [15:0]            temp_word;

  fgscm_pin_sync u_scl_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .pin   (pin_in.scl),
    .lvl   (scl)
  );

  fgscm_pin_sync u_sda_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .pin   (pin_in.sda),
    .lvl   (sda)
  );

  fgscm_pwr u_pwr (
    .clk        (clk),
    .rst_b      (rst_b),
    .req        (r.preq),
    .sleep_ok   (sleep_ok),
    .power_fail (power_fail),
    .mode       (pwr_mode)
  );

  assign rise      = !r.scl_d && scl;
  assign fall      = r.scl_d && !scl;
  assign start     = r.scl_d && scl && r.sda_d && !sda;
  assign stop      = r.scl_d && scl && !r.sda_d && sda;
  assign byte_done = fall && r.bitcnt == fgscm_pkg::BITS_PER_BYTE;
  assign wr_fire   = !start && !stop && r.st == fgscm_pkg::I2C_WR_BYTE && byte_done && !r.first;
  // block select picks one 32-byte block, low code bits give the offset
  assign mib_idx   = {r.mib_sel, 5'h00} + {2'h0, r.ptr[4:0]};
  assign temp_word = temp_src_internal ? therm_int : therm_ext;

  // byte returned for a command code
  function automatic logic [7:0] rd_byte(input logic [7:0] p);
    logic [15:0] w;
    logic [6:0]  mi;
    w  = 16'h0000;
    mi = {r.mib_sel, 5'h00} + {2'h0, p[4:0]};
    case (p & 8'hFE)
      fgscm_pkg::CMD_CTRL:         w = ctrl_rsp;
      fgscm_pkg::CMD_AT_RATE:      w = r.at_rate;
      fgscm_pkg::CMD_AT_RATE_EMPT: w = meas.at_rate_empt;
      fgscm_pkg::CMD_THERMAL:      w = temp_word;
      fgscm_pkg::CMD_POTENTIAL:    w = meas.potential_mv;
      fgscm_pkg::CMD_STATUS_BITS:  w = meas.status_bits;
      fgscm_pkg::CMD_NOM_CAP:      w = meas.nom_cap;
      fgscm_pkg::CMD_FULL_AVAIL:   w = meas.full_avail_cap;
      fgscm_pkg::CMD_REMAIN:       w = meas.remain_cap;
      fgscm_pkg::CMD_FULL_CHG:     w = meas.full_chg_cap;
      fgscm_pkg::CMD_AVG_CUR:      w = meas.avg_current;
      fgscm_pkg::CMD_EMPTY_TIME:   w = meas.empty_time;
      fgscm_pkg::CMD_FULL_TIME:    w = meas.full_time;
      fgscm_pkg::CMD_STBY_CUR:     w = meas.stby_current;
      fgscm_pkg::CMD_STBY_EMPTY:   w = meas.stby_empty;
      fgscm_pkg::CMD_MAXL_CUR:     w = meas.maxl_current;
      fgscm_pkg::CMD_MAXL_EMPTY:   w = meas.maxl_empty;
      fgscm_pkg::CMD_AVAIL_ENERGY: w = meas.avail_energy;
      fgscm_pkg::CMD_AVG_POWER:    w = meas.avg_power;
      fgscm_pkg::CMD_CP_EMPTY:     w = meas.cp_empty;
      fgscm_pkg::CMD_RESERVED:     w = 16'h0000;
      fgscm_pkg::CMD_CYCLES:       w = meas.cycles;
      fgscm_pkg::CMD_CHARGE_PCT:   w = meas.charge_pct;
      default:                     w = 16'h0000;
    endcase
    if (p >= fgscm_pkg::CMD_MIB_FIRST && p <= fgscm_pkg::CMD_MIB_LAST) begin
      rd_byte = r.mib[mi];
    end else if (p == fgscm_pkg::CMD_MIB_SEL) begin
      rd_byte = {6'h00, r.mib_sel};
    end else begin
      rd_byte = p[0] ? w[15:8] : w[7:0];
    end
  endfunction

  always_comb begin
    next_r = r;
    next_r.scl_d = scl;
    next_r.sda_d = sda;
    next_r.ctrl_valid = 1'b0;
    next_r.preq = '0;
    if (start) begin
      next_r.st = fgscm_pkg::I2C_ADDR;
      next_r.bitcnt = 4'h0;
      next_r.sda_oe_b = 1'b1;
      next_r.preq.bus_wake = 1'b1;
    end else if (stop) begin
      next_r.st = fgscm_pkg::I2C_IDLE;
      next_r.sda_oe_b = 1'b1;
    end else begin
      case (r.st)
        fgscm_pkg::I2C_IDLE: begin
          next_r.sda_oe_b = 1'b1;
        end
        fgscm_pkg::I2C_ADDR: begin
          if (rise && r.bitcnt < fgscm_pkg::BITS_PER_BYTE) begin
            next_r.shreg = {r.shreg[6:0], sda};
            next_r.bitcnt = r.bitcnt + 4'h1;
          end else if (byte_done) begin
            if (r.shreg[7:1] == DEV_ADDR && pwr_mode == fgscm_pkg::PWR_NORMAL) begin
              next_r.sda_oe_b = 1'b0;
              next_r.rd = r.shreg[0];
              next_r.first = !r.shreg[0];
              next_r.st = fgscm_pkg::I2C_ACK_ADDR;
            end else begin
              next_r.st = fgscm_pkg::I2C_IDLE;
            end
          end
        end
        fgscm_pkg::I2C_ACK_ADDR: begin
          if (fall) begin
            if (r.rd) begin
              next_r.shreg = rd_byte(r.ptr);
              next_r.sda_oe_b = next_r.shreg[7];
              next_r.bitcnt = 4'h1;
              next_r.st = fgscm_pkg::I2C_RD_BYTE;
            end else begin
              next_r.sda_oe_b = 1'b1;
              next_r.bitcnt = 4'h0;
              next_r.st = fgscm_pkg::I2C_WR_BYTE;
            end
          end
        end
        fgscm_pkg::I2C_WR_BYTE: begin
          if (rise && r.bitcnt < fgscm_pkg::BITS_PER_BYTE) begin
            next_r.shreg = {r.shreg[6:0], sda};
            next_r.bitcnt = r.bitcnt + 4'h1;
          end else if (byte_done) begin
            next_r.sda_oe_b = 1'b0;
            next_r.st = fgscm_pkg::I2C_ACK_WR;
            if (r.first) begin
              // first byte after the address selects the command code
              next_r.ptr = r.shreg;
              next_r.first = 1'b0;
            end else begin
              next_r.ptr = r.ptr + 8'h01;
              case (r.ptr)
                fgscm_pkg::CMD_CTRL: next_r.ctrl_lo = r.shreg;
                fgscm_pkg::CMD_CTRL + 8'h01: begin
                  // subcommand completes on its high byte
                  next_r.ctrl_word = {r.shreg, r.ctrl_lo};
                  next_r.ctrl_valid = 1'b1;
                  case ({r.shreg, r.ctrl_lo})
                    fgscm_pkg::SUB_SET_DEEP:    next_r.preq.deep_set = 1'b1;
                    fgscm_pkg::SUB_SET_DORMANT: next_r.preq.dormant_set = 1'b1;
                    fgscm_pkg::SUB_CLR_DORMANT: next_r.preq.dormant_clr = 1'b1;
                    fgscm_pkg::SUB_SET_PREOFF:  next_r.preq.preoff_en = 1'b1;
                    fgscm_pkg::SUB_CLR_PREOFF:  next_r.preq.preoff_dis = 1'b1;
                    fgscm_pkg::SUB_LOCK:        next_r.locked = 1'b1;
                    default:                    next_r.locked = r.locked;
                  endcase
                end
                fgscm_pkg::CMD_AT_RATE: next_r.at_rate[7:0] = r.shreg;
                fgscm_pkg::CMD_AT_RATE + 8'h01: next_r.at_rate[15:8] = r.shreg;
                fgscm_pkg::CMD_MIB_SEL: begin
                  if (r.shreg < fgscm_pkg::MIB_BLOCKS) next_r.mib_sel = r.shreg[1:0];
                end
                default: begin
                  // every other standard pair is read-only, reserved pair included
                  if (r.ptr >= fgscm_pkg::CMD_MIB_FIRST && r.ptr <= fgscm_pkg::CMD_MIB_LAST) begin
                    next_r.mib[mib_idx] = r.shreg;
                  end
                end
              endcase
            end
          end
        end
        fgscm_pkg::I2C_ACK_WR: begin
          if (fall) begin
            next_r.sda_oe_b = 1'b1;
            next_r.bitcnt = 4'h0;
            next_r.st = fgscm_pkg::I2C_WR_BYTE;
          end
        end
        fgscm_pkg::I2C_RD_BYTE: begin
          if (byte_done) begin
            next_r.sda_oe_b = 1'b1;
            next_r.ptr = r.ptr + 8'h01;
            next_r.st = fgscm_pkg::I2C_ACK_RD;
          end else if (fall) begin
            next_r.sda_oe_b = r.shreg[6];
            next_r.shreg = {r.shreg[6:0], 1'b0};
            next_r.bitcnt = r.bitcnt + 4'h1;
          end
        end
        fgscm_pkg::I2C_ACK_RD: begin
          if (rise) begin
            next_r.ackd = !sda;
          end else if (fall) begin
            if (r.ackd) begin
              next_r.shreg = rd_byte(r.ptr);
              next_r.sda_oe_b = next_r.shreg[7];
              next_r.bitcnt = 4'h1;
              next_r.st = fgscm_pkg::I2C_RD_BYTE;
            end else begin
              next_r.st = fgscm_pkg::I2C_IDLE;
            end
          end
        end
        default: next_r.st = fgscm_pkg::I2C_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      r <= fgscm_pkg::CORE_RST;
    end else begin
      r <= next_r;
    end
  end

  assign pin_out.sda_out   = r.sda_out;
  assign pin_out.sda_oe_b  = r.sda_oe_b;
  assign ctrl_cmd.valid    = r.ctrl_valid;
  assign ctrl_cmd.word     = r.ctrl_word;
  assign at_rate_setpoint  = r.at_rate;
  assign locked            = r.locked;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  logic rd_load;
  assign rd_load = !start && !stop && fall && ((r.st == fgscm_pkg::I2C_ACK_ADDR && r.rd)
                   || (r.st == fgscm_pkg::I2C_ACK_RD && r.ackd));

  sequence s_addr_hit;
    !start && !stop && r.st == fgscm_pkg::I2C_ADDR && byte_done
      && r.shreg[7:1] == DEV_ADDR && pwr_mode == fgscm_pkg::PWR_NORMAL;
  endsequence
  sequence s_ack_held;
    r.st == fgscm_pkg::I2C_ACK_ADDR && !r.sda_oe_b;
  endsequence

  a_addr_ack: assert property (s_addr_hit |=> s_ack_held)
    else $error("address match not acknowledged");
  a_asleep_nack: assert property ((!start && !stop && r.st == fgscm_pkg::I2C_ADDR && byte_done
      && pwr_mode != fgscm_pkg::PWR_NORMAL) |=> (r.st == fgscm_pkg::I2C_IDLE && r.sda_oe_b))
    else $error("address answered outside normal mode");
  a_pair_bytes: assert property ((rd_load && r.ptr == fgscm_pkg::CMD_POTENTIAL + 8'h01)
      |=> r.shreg == $past(meas.potential_mv[15:8]))
    else $error("odd code did not return the high byte");
  a_ptr_advance: assert property ((!start && !stop && r.st == fgscm_pkg::I2C_RD_BYTE && byte_done)
      |=> (r.ptr == $past(r.ptr) + 8'h01 && r.st == fgscm_pkg::I2C_ACK_RD))
    else $error("read pointer did not advance after a byte");
  a_at_rate_src: assert property ($changed(r.at_rate) |-> $past(wr_fire)
      && ($past(r.ptr) & 8'hFE) == fgscm_pkg::CMD_AT_RATE)
    else $error("at-rate word changed without a write to its pair");
  a_reserved_zero: assert property ((rd_load && (r.ptr & 8'hFE) == fgscm_pkg::CMD_RESERVED)
      |=> r.shreg == 8'h00)
    else $error("reserved pair read non-zero");
  a_temp_source: assert property ((rd_load && r.ptr == fgscm_pkg::CMD_THERMAL)
      |=> r.shreg == $past(temp_src_internal ? therm_int[7:0] : therm_ext[7:0]))
    else $error("temperature taken from the wrong source");
  a_ctrl_pulse: assert property ((wr_fire && r.ptr == fgscm_pkg::CMD_CTRL + 8'h01)
      |=> (ctrl_cmd.valid && ctrl_cmd.word == {$past(r.shreg), $past(r.ctrl_lo)})
      ##1 !ctrl_cmd.valid)
    else $error("subcommand not issued as a single pulse");
  a_mib_store: assert property ((wr_fire && r.ptr >= fgscm_pkg::CMD_MIB_FIRST
      && r.ptr <= fgscm_pkg::CMD_MIB_LAST) |=> r.mib[$past(mib_idx)] == $past(r.shreg))
    else $error("user storage byte not stored");
endmodule

// ==== dv/fgscm_host.sv ====
// host processor model on the two-wire port, open drain with pull-up
`timescale 1ns/1ps
module fgscm_host (
  // clock
  input  wire logic clk,
  // device side of the data line
  input  wire logic dev_oe_b,
  // resolved bus lines
  output logic      scl,
  output logic      sda
);
  localparam int Q = 10;
  logic host_oe_b;
  // either party pulling low wins, released reads high
  assign sda = host_oe_b & dev_oe_b;
  initial begin
    scl = 1'b1;
    host_oe_b = 1'b1;
  end
  task automatic wait_q();
    repeat (Q) @(posedge clk);
    #1;
  endtask
  // also serves as repeated start with scl low
  task automatic start_c();
    host_oe_b = 1'b1;
    wait_q();
    scl = 1'b1;
    wait_q();
    host_oe_b = 1'b0;
    wait_q();
    scl = 1'b0;
    wait_q();
  endtask
  task automatic stop_c();
    host_oe_b = 1'b0;
    wait_q();
    scl = 1'b1;
    wait_q();
    host_oe_b = 1'b1;
    wait_q();
  endtask
  task automatic bit_io(input logic b, output logic r);
    host_oe_b = b;
    wait_q();
    scl = 1'b1;
    wait_q();
    r = sda;
    wait_q();
    scl = 1'b0;
    wait_q();
  endtask
  task automatic send(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task automatic recv(input logic ack, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      b[i] = r;
    end
    bit_io(!ack, r);
  endtask
endmodule

// ==== dv/fgscm_bench.sv ====
// self-checking bench of the standard-command map
`timescale 1ns/1ps
module fgscm_bench;
  localparam logic [6:0] ADDR = fgscm_pkg::DEV_ADDR_DFLT;
  logic clk, rst_b, scl_w, sda_w, temp_src_internal, sleep_ok, power_fail, locked;
  logic [15:0] therm_ext, therm_int, ctrl_rsp, at_rate_setpoint;
  logic [31:0] d;
  fgscm_pkg::fgscm_meas_t    meas;
  fgscm_pkg::fgscm_pin_in_t  pin_in;
  fgscm_pkg::fgscm_pin_out_t pin_out;
  fgscm_pkg::fgscm_ctrl_t    ctrl_cmd;
  fgscm_pkg::fgscm_pwr_t     pwr_mode;
  int num_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  int pulses = 0;
  always @(posedge clk) begin
    if (ctrl_cmd.valid) pulses <= pulses + 1;
  end
  assign pin_in = {scl_w, sda_w};
  fgscm_top dut_u (.clk(clk), .rst_b(rst_b), .pin_in(pin_in), .pin_out(pin_out),
    .meas(meas), .therm_ext(therm_ext), .therm_int(therm_int),
    .temp_src_internal(temp_src_internal), .ctrl_rsp(ctrl_rsp), .sleep_ok(sleep_ok),
    .power_fail(power_fail), .ctrl_cmd(ctrl_cmd), .at_rate_setpoint(at_rate_setpoint),
    .locked(locked), .pwr_mode(pwr_mode));
  fgscm_host host_u (.clk(clk), .dev_oe_b(pin_out.sda_oe_b), .scl(scl_w), .sda(sda_w));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      num_errors++;
      complete_run();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // code selection, then n data bytes low first
  task automatic wr(input logic [7:0] code, input int n, input logic [31:0] v);
    logic a;
    host_u.start_c();
    host_u.send({ADDR, 1'b0}, a);
    check({31'h0, a}, 32'h1);
    host_u.send(code, a);
    for (int i = 0; i < n; i++) host_u.send(v[8*i+:8], a);
    host_u.stop_c();
  endtask
  task automatic rd(input logic [7:0] code, input int n, output logic [31:0] v);
    logic a;
    logic [7:0] b;
    v = '0;
    host_u.start_c();
    host_u.send({ADDR, 1'b0}, a);
    host_u.send(code, a);
    host_u.start_c();
    host_u.send({ADDR, 1'b1}, a);
    for (int i = 0; i < n; i++) begin
      host_u.recv(i < n - 1, b);
      v[8*i+:8] = b;
    end
    host_u.stop_c();
  endtask
  task automatic t_reset();
    check({31'h0, pin_out.sda_oe_b}, 32'h1);
    check({31'h0, pin_out.sda_out}, 32'h0);
    check({15'h0, locked, at_rate_setpoint}, 32'h0);
    check({15'h0, ctrl_cmd}, 32'h0);
    check({29'h0, pwr_mode}, {29'h0, fgscm_pkg::PWR_NORMAL});
    $display("test reset done");
  endtask
  task automatic t_read();
    rd(8'h06, 4, d);
    check(d, 32'h0E74_0BA5);
    temp_src_internal = 1'b1;
    rd(8'h06, 2, d);
    check(d, 32'h0000_0B9A);
    rd(8'h00, 4, d);
    check(d, 32'h0000_5A3C);
    $display("test read done");
  endtask
  task automatic t_read_only();
    wr(8'h08, 2, 32'h1111);
    rd(8'h08, 2, d);
    check(d, 32'h0E74);
    wr(8'h28, 2, 32'hFFFF);
    rd(8'h28, 4, d);
    check(d, 32'h0123_0000);
    $display("test read-only done");
  endtask
  task automatic t_storage();
    wr(8'h3E, 1, 32'h1);
    wr(8'h40, 4, 32'hC3D2_E1F0);
    wr(8'h3E, 1, 32'h2);
    wr(8'h40, 4, 32'h0F1E_2D3C);
    wr(8'h3E, 1, 32'h1);
    wr(8'h3E, 1, 32'h3);
    rd(8'h3E, 1, d);
    check(d, 32'h1);
    rd(8'h40, 4, d);
    check(d, 32'hC3D2_E1F0);
    $display("test storage done");
  endtask
  task automatic t_power();
    logic a;
    sleep_ok = 1'b1;
    tick(10);
    check({29'h0, pwr_mode}, {29'h0, fgscm_pkg::PWR_LIGHT_SLEEP});
    host_u.start_c();
    host_u.send({ADDR, 1'b0}, a);
    host_u.stop_c();
    check({31'h0, a}, 32'h0);
    sleep_ok = 1'b0;
    tick(10);
    check({29'h0, pwr_mode}, {29'h0, fgscm_pkg::PWR_NORMAL});
    wr(8'h00, 2, {16'h0, fgscm_pkg::SUB_SET_PREOFF});
    power_fail = 1'b1;
    tick(10);
    check({29'h0, pwr_mode}, {29'h0, fgscm_pkg::PWR_PRE_POWER_OFF});
    power_fail = 1'b0;
    tick(10);
    check({29'h0, pwr_mode}, {29'h0, fgscm_pkg::PWR_NORMAL});
    wr(8'h00, 2, {16'h0, fgscm_pkg::SUB_CLR_PREOFF});
    power_fail = 1'b1;
    tick(10);
    check({29'h0, pwr_mode}, {29'h0, fgscm_pkg::PWR_NORMAL});
    power_fail = 1'b0;
    tick(10);
    $display("test power done");
  endtask
  task automatic t_sleep();
    logic a;
    wr(8'h00, 2, {16'h0, fgscm_pkg::SUB_SET_DEEP});
    sleep_ok = 1'b1;
    tick(10);
    check({29'h0, pwr_mode}, {29'h0, fgscm_pkg::PWR_DEEP_SLEEP});
    host_u.start_c();
    host_u.send({ADDR, 1'b0}, a);
    host_u.stop_c();
    check({31'h0, a}, 32'h0);
    check({29'h0, pwr_mode}, {29'h0, fgscm_pkg::PWR_LIGHT_SLEEP});
    sleep_ok = 1'b0;
    tick(10);
    wr(8'h00, 2, {16'h0, fgscm_pkg::SUB_SET_DORMANT});
    sleep_ok = 1'b1;
    tick(10);
    check({29'h0, pwr_mode}, {29'h0, fgscm_pkg::PWR_DORMANT});
    sleep_ok = 1'b0;
    tick(10);
    check({29'h0, pwr_mode}, {29'h0, fgscm_pkg::PWR_NORMAL});
    wr(8'h00, 2, {16'h0, fgscm_pkg::SUB_SET_DORMANT});
    wr(8'h00, 2, {16'h0, fgscm_pkg::SUB_CLR_DORMANT});
    sleep_ok = 1'b1;
    tick(10);
    check({29'h0, pwr_mode}, {29'h0, fgscm_pkg::PWR_LIGHT_SLEEP});
    sleep_ok = 1'b0;
    tick(10);
    $display("test sleep done");
  endtask
  task automatic t_lock();
    int p;
    p = pulses;
    wr(8'h00, 2, {16'h0, fgscm_pkg::SUB_LOCK});
    check(32'(pulses - p), 32'h1);
    check({15'h0, locked, ctrl_cmd.word}, {16'h1, fgscm_pkg::SUB_LOCK});
    wr(8'h02, 2, 32'hBEEF);
    check({16'h0, at_rate_setpoint}, 32'hBEEF);
    wr(8'h08, 2, 32'h2222);
    rd(8'h02, 2, d);
    check(d, 32'h0000_BEEF);
    rd(8'h08, 2, d);
    check(d, 32'h0E74);
    $display("test lock done");
  endtask
  initial begin
    rst_b = 1'b0;
    meas = '0;
    meas.potential_mv = 16'h0E74;
    meas.cycles = 16'h0123;
    therm_ext = 16'h0BA5;
    therm_int = 16'h0B9A;
    ctrl_rsp = 16'h5A3C;
    temp_src_internal = 1'b0;
    sleep_ok = 1'b0;
    power_fail = 1'b0;
    tick(8);
    rst_b = 1'b1;
    tick(8);
    t_reset();
    t_read();
    t_read_only();
    t_storage();
    t_power();
    t_sleep();
    t_lock();
    complete_run();
  end
endmodule
